// ==== design/hdlc_rx_source_pkg.sv ====
package hdlc_rx_source_pkg;

  // Register word indices on the Wishbone bus (byte address is index * 4).
  localparam logic [7:0] TX_FIFO_WRITE_IDX  = 8'hb7;
  localparam logic [7:0] RX_SOURCE_CTRL_IDX = 8'hb8;
  localparam logic [7:0] RX_GENERAL_TWO_IDX = 8'hc0;
  localparam logic [7:0] RX_BLOCK_MAP_IDX   = 8'hc1;
  localparam logic [7:0] TX_FIFO_STATUS_IDX = 8'hc2;
  localparam int         ADDR_W             = 10;

  // Field positions of the receive source control register.
  localparam int OVERRIDE_BIT  = 7;
  localparam int SPARE_SEL_BIT = 6;
  localparam int MODE_BIT      = 5;
  localparam int SLOT_MSB      = 4;

  // Sa-bit select field of the general receive control register.
  localparam int GEN_SA_LSB = 3;

  localparam logic [7:0]  SOURCE_CTRL_RESET = 8'h00;
  localparam logic [7:0]  GENERAL_TWO_RESET = 8'h00;
  localparam logic [31:0] BLOCK_MAP_RESET   = 32'h0000_0000;
  localparam int          TX_FIFO_DEPTH     = 64;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SPARE,
    SRC_SLOT
  } rx_source_t;

  // Position within the received frame, as reported by the framer.
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [2:0] bit_pos;
    logic       is_spare;
    logic [2:0] spare_idx;
    logic       data;
  } frame_bit_t;

  typedef struct packed {
    logic       valid;
    logic       data;
  } hdlc_bit_t;

endpackage

// ==== design/hdlc_rx_source_select.sv ====
// Operation
// RQ1: With the source override at 0 the receiver is fed from the Sa bits of the general control register, at 1 from this register's own selection.
// RQ2: With spare-or-slot select at 0 Sa bits are routed, field bit 4 enabling Sa4 down to bit 0 enabling Sa8.
// RQ3: With spare-or-slot select at 1 time-slot contents are routed and the mode bit picks the slots.
// RQ4: With mode 0 the single slot numbered by the five-bit field is used.
// RQ5: With mode 1 every slot marked in the channel block map is used.
// RQ6: The five-bit field is a binary slot number, bit 4 most significant.
// RQ7: The host writes transmit bytes at address b7, bit 7 the most significant.
// RQ8: The transmit FIFO not-full flag is high while at least one byte is free.
// RQ9: The select, mode and slot fields count only while the override is 1.
//
// The block sits between the receive framer and the HDLC receiver. Every
// cycle the framer presents at most one received bit, tagged with its slot,
// its position in the slot and, for spare bits, the Sa index. The block
// decides from the control registers whether that bit belongs to the HDLC
// stream and passes it on one cycle later with a valid flag.
//
// The Sa index travels as three bits, so Sa8 arrives coded as zero. Both
// the range test and the enable lookup below treat zero as Sa8; a framer
// that never sends index zero simply never feeds Sa8 into the receiver.
//
// The host side is a classic Wishbone slave with one wait state. Every
// mapped access is answered by ack, every unmapped one by err, both one
// cycle after the request is taken and both lasting a single cycle. The
// request is refused while an answer is still showing, so a master that
// holds its strobe through the answer cycle is never served twice.
//
// The transmit FIFO write port takes its byte from lane 0 only. A write
// while the FIFO is full is dropped without any error, which mirrors the
// behaviour of a simple byte port; software is expected to poll the
// not-full flag first.
//
// Register access over Wishbone was chosen for this implementation.
module hdlc_rx_source_select #(
  parameter int FIFO_DEPTH = hdlc_rx_source_pkg::TX_FIFO_DEPTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [hdlc_rx_source_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  input  wire hdlc_rx_source_pkg::frame_bit_t frame_bit_i,
  output hdlc_rx_source_pkg::hdlc_bit_t       hdlc_bit_o,
  input  wire logic                          tx_rd_i,
  output logic      [7:0]                    tx_data_o,
  output logic                               tx_empty_o,
  output logic                               tx_not_full_o
);

  logic [7:0]  source_ctrl_ff;
  logic [7:0]  general_two_ff;
  logic [31:0] block_map_ff;
  logic [31:0] rd_data_ff;
  logic        ack_ff;
  logic        err_ff;
  hdlc_rx_source_pkg::hdlc_bit_t hdlc_bit_ff;
  logic [7:0]  fifo_head;
  logic        fifo_empty;
  logic        fifo_full;
  logic        fifo_not_full;

  function automatic logic [7:0] word_index(
    input logic [hdlc_rx_source_pkg::ADDR_W-1:0] adr
  );
    word_index = adr[9:2];
  endfunction

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  wire       req       = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  wire [7:0] idx       = word_index(wb_adr_i);
  wire       hit_fifo  = idx == hdlc_rx_source_pkg::TX_FIFO_WRITE_IDX;
  wire       hit_ctrl  = idx == hdlc_rx_source_pkg::RX_SOURCE_CTRL_IDX;
  wire       hit_gen   = idx == hdlc_rx_source_pkg::RX_GENERAL_TWO_IDX;
  wire       hit_map   = idx == hdlc_rx_source_pkg::RX_BLOCK_MAP_IDX;
  wire       hit_stat  = idx == hdlc_rx_source_pkg::TX_FIFO_STATUS_IDX;
  wire       mapped    = hit_fifo | hit_ctrl | hit_gen | hit_map | hit_stat;
  wire       wr_ok     = req && wb_we_i && mapped;
  // A byte only enters the FIFO when the low lane is enabled.
  wire       fifo_wr   = wr_ok && hit_fifo && wb_sel_i[0]; // RQ7

  wire [31:0] nxt_rd_data =
    hit_ctrl ? {24'h0, source_ctrl_ff} :
    hit_gen  ? {24'h0, general_two_ff} :
    hit_map  ? block_map_ff :
    hit_stat ? {29'h0, fifo_full, fifo_empty, fifo_not_full} :
    32'h0;

  // Source selection from the current frame position.
  wire       override   = source_ctrl_ff[hdlc_rx_source_pkg::OVERRIDE_BIT];
  wire       spare_sel  = source_ctrl_ff[hdlc_rx_source_pkg::SPARE_SEL_BIT];
  wire       slot_mode  = source_ctrl_ff[hdlc_rx_source_pkg::MODE_BIT];
  wire [4:0] slot_field = source_ctrl_ff[hdlc_rx_source_pkg::SLOT_MSB:0];
  wire [4:0] gen_sa     =
    general_two_ff[hdlc_rx_source_pkg::GEN_SA_LSB +: 5];
  // Sa index 4..8 maps onto enable bit 8 - index, so Sa4 is bit 4.
  wire [2:0] sa_bit     = 3'h0 - frame_bit_i.spare_idx;
  // Index zero stands for Sa8, which wraps around the three-bit code.
  wire       sa_in_rng  = (frame_bit_i.spare_idx >= 3'h4) ||
                          (frame_bit_i.spare_idx == 3'h0); // RQ2
  wire       use_own    = override; // RQ1 RQ9
  wire [4:0] sa_enables = use_own ? slot_field : gen_sa; // RQ1 RQ2
  wire       sa_hit     = frame_bit_i.is_spare && sa_in_rng &&
                          sa_enables[sa_bit]; // RQ2
  wire       slot_hit   = !frame_bit_i.is_spare &&
    (slot_mode ? block_map_ff[frame_bit_i.slot]         // RQ5
               : (frame_bit_i.slot == slot_field));     // RQ4 RQ6

  // The source is decided once per bit from the registered controls, so a
  // register write takes effect from the next frame bit onwards and never
  // splits a bit between two sources.
  hdlc_rx_source_pkg::rx_source_t source;
  assign source = (use_own && spare_sel) ? hdlc_rx_source_pkg::SRC_SLOT
                                         : hdlc_rx_source_pkg::SRC_SPARE;

  wire take_bit = frame_bit_i.valid &&
    ((source == hdlc_rx_source_pkg::SRC_SLOT) ? slot_hit   // RQ3
                                              : sa_hit);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_ctrl_ff <= hdlc_rx_source_pkg::SOURCE_CTRL_RESET;
      general_two_ff <= hdlc_rx_source_pkg::GENERAL_TWO_RESET;
      block_map_ff   <= hdlc_rx_source_pkg::BLOCK_MAP_RESET;
    end else if (ce_i && wr_ok) begin
      if (hit_ctrl && wb_sel_i[0]) begin
        source_ctrl_ff <= wb_dat_i[7:0];
      end
      if (hit_gen && wb_sel_i[0]) begin
        general_two_ff <= wb_dat_i[7:0];
      end
      if (hit_map) begin
        block_map_ff <= lane_merge(block_map_ff, wb_dat_i, wb_sel_i); // RQ5
      end
    end
  end

  // Single-wait-state slave: ack or err one cycle after the request.
  // Read data is cleared outside read answers, so a stale word is never
  // left on the bus where a careless master could mistake it for data.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff     <= 1'b0;
      err_ff     <= 1'b0;
      rd_data_ff <= 32'h0;
    end else if (ce_i) begin
      ack_ff     <= req && mapped;
      err_ff     <= req && !mapped;
      rd_data_ff <= (req && !wb_we_i) ? nxt_rd_data : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdlc_bit_ff <= '0;
    end else if (ce_i) begin
      hdlc_bit_ff.valid <= take_bit;
      hdlc_bit_ff.data  <= take_bit & frame_bit_i.data;
    end
  end

  tx_byte_fifo #(
    .DEPTH (FIFO_DEPTH),
    .WIDTH (8)
  ) u_tx_fifo (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .wr_i       (fifo_wr),
    .wr_data_i  (wb_dat_i[7:0]),
    .rd_i       (tx_rd_i),
    .rd_data_o  (fifo_head),
    .empty_o    (fifo_empty),
    .full_o     (fifo_full),
    .not_full_o (fifo_not_full)
  );

  // The transmit side sees the FIFO through registers, which costs one
  // cycle of latency on the head byte and the flags but keeps every output
  // of the block straight from a flip-flop.
  logic [7:0] tx_data_ff;
  logic       tx_empty_ff;
  logic       tx_not_full_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_ff     <= 8'h0;
      tx_empty_ff    <= 1'b1;
      tx_not_full_ff <= 1'b1;
    end else if (ce_i) begin
      tx_data_ff     <= fifo_head;
      tx_empty_ff    <= fifo_empty;
      tx_not_full_ff <= fifo_not_full; // RQ8
    end
  end

  assign wb_dat_o      = rd_data_ff;
  assign wb_ack_o      = ack_ff;
  assign wb_err_o      = err_ff;
  assign hdlc_bit_o    = hdlc_bit_ff;
  assign tx_data_o     = tx_data_ff;
  assign tx_empty_o    = tx_empty_ff;
  assign tx_not_full_o = tx_not_full_ff;

endmodule

// ==== design/tx_byte_fifo.sv ====
module tx_byte_fifo #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_i,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  empty_o,
  output logic                  full_o,
  output logic                  not_full_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  wire              do_wr = wr_i && (cnt_ff != (AW+1)'(DEPTH));
  wire              do_rd = rd_i && (cnt_ff != '0);

  assign rd_data_o  = mem_ff[rp_ff];
  assign empty_o    = (cnt_ff == '0);
  assign full_o     = (cnt_ff == (AW+1)'(DEPTH));
  assign not_full_o = !full_o; // RQ8

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (do_wr) begin
        mem_ff[wp_ff] <= wr_data_i;
        wp_ff         <= wp_ff + AW'(1);
      end
      if (do_rd) begin
        rp_ff <= rp_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule

// ==== tb/frame_source_model.sv ====
module frame_source_model (
  input  wire logic                      clk_i,
  input  wire logic                      go_i,
  output hdlc_rx_source_pkg::frame_bit_t frame_bit_o,
  output logic                           done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_ff = 9'h000;
  logic       run_ff = 1'b0;
  logic       tog_ff = 1'b0;
  // A frame is 256 slot bits, then Sa4 to Sa8. The first five bits of each slot carry the
  // slot number, MSB first, the last three are zero, so a wrong slot or bit order shows in the data.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    tog_ff <= ~tog_ff;
    if (go_i) begin
      run_ff <= 1'b1;
      cnt_ff <= 9'h000;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff + 9'h001;
      run_ff <= (cnt_ff != 9'h104);
      done_o <= (cnt_ff == 9'h104);
    end
  end
  // Outside frames the data line toggles, so no stale bit can pass as real.
  always_comb begin
    frame_bit_o = '0;
    frame_bit_o.valid = run_ff;
    frame_bit_o.slot = cnt_ff[7:3];
    frame_bit_o.bit_pos = cnt_ff[2:0];
    frame_bit_o.is_spare = cnt_ff[8];
    frame_bit_o.spare_idx = (cnt_ff[2:0] == 3'h4) ? 3'h0
                                                  : 3'h4 + cnt_ff[2:0];
    if (!run_ff) begin
      frame_bit_o.data = tog_ff;
    end else if (cnt_ff[8]) begin
      frame_bit_o.data = 1'b1;
    end else if (cnt_ff[2:0] < 3'h5) begin
      frame_bit_o.data = cnt_ff[3'h7 - cnt_ff[2:0]];
    end
  end
endmodule

// ==== tb/hdlc_rx_source_assertions.sv ====
module hdlc_rx_source_assertions (
  input wire logic                           clk_i,
  input wire logic                           rst_i,
  input wire logic                           wb_cyc_i,
  input wire logic                           wb_stb_i,
  input wire logic                           wb_ack_o,
  input wire logic                           wb_err_o,
  input wire hdlc_rx_source_pkg::frame_bit_t frame_bit_i,
  input wire hdlc_rx_source_pkg::hdlc_bit_t  hdlc_bit_o,
  input wire logic                           tx_empty_o,
  input wire logic                           tx_not_full_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  answer_time_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("bus answer not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  err_pulse_a: assert property (wb_err_o |=> !wb_err_o)
    else $error("err longer than one cycle");
  one_answer_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  bit_latency_a: assert property (
    hdlc_bit_o.valid |-> $past(frame_bit_i.valid))
    else $error("receiver bit without a frame bit");
  bit_data_a: assert property (
    hdlc_bit_o.valid |-> hdlc_bit_o.data == $past(frame_bit_i.data))
    else $error("receiver bit data differs from frame bit");
  reset_levels_a: assert property (disable iff (1'b0)
    rst_i |=> tx_empty_o && tx_not_full_o && !hdlc_bit_o.valid)
    else $error("wrong levels after reset");
  empty_free_a: assert property (tx_empty_o |-> tx_not_full_o)
    else $error("empty fifo flagged full");
endmodule

bind hdlc_rx_source_select hdlc_rx_source_assertions chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .frame_bit_i(frame_bit_i),
  .hdlc_bit_o(hdlc_bit_o), .tx_empty_o(tx_empty_o),
  .tx_not_full_o(tx_not_full_o));

// ==== tb/tb_hdlc_rx_source_select.sv ====
module tb_hdlc_rx_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic        got_err;
  logic        ack;
  logic        err;
  logic        go = 1'b0;
  logic        rd = 1'b0;
  logic        ce = 1'b1;
  logic        done;
  logic [7:0]  txd;
  logic        emp;
  logic        nf;
  logic [7:0]  sh = 8'h00;
  int          cnt = 0;
  int          num_errors = 0;
  int          cmp_count = 0;
  hdlc_rx_source_pkg::frame_bit_t fb;
  hdlc_rx_source_pkg::hdlc_bit_t  hb;

  always #5 clk_i = ~clk_i;

  hdlc_rx_source_select #(.FIFO_DEPTH(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .frame_bit_i(fb), .hdlc_bit_o(hb), .tx_rd_i(rd), .tx_data_o(txd),
    .tx_empty_o(emp), .tx_not_full_o(nf));
  frame_source_model src (.clk_i(clk_i), .go_i(go), .frame_bit_o(fb),
    .done_o(done));

  always @(posedge clk_i) begin
    if (go) begin
      cnt <= 0;
      sh <= 8'h00;
    end else if (hb.valid === 1'b1) begin
      cnt <= cnt + 1;
      sh <= {sh[6:0], hb.data};
    end
  end

  task automatic end_sim();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic [7:0] i, input logic w, input logic [3:0] s,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {i, 2'b00};
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack || err) && n < 20);
    if (!(ack || err)) begin
      num_errors++;
      end_sim();
    end
    q = dat_o;
    got_err = err;
    cyc <= 1'b0;
  endtask

  task automatic run(input int ec, input logic [7:0] eb);
    int n;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    while (!done && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (!done) begin
      num_errors++;
      end_sim();
    end
    repeat (3) @(posedge clk_i);
    chk("bit count", ec, cnt);
    chk("last byte", {24'h0, eb}, {24'h0, sh});
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("tx empty", 1, emp);
    chk("tx not full", 1, nf);
    bus(8'hc0, 1'b1, 4'h1, 32'h80);
    bus(8'hb8, 1'b1, 4'h1, 32'h45);
    run(1, 8'h01);
    bus(8'hb8, 1'b1, 4'h1, 32'h98);
    run(2, 8'h03);
    bus(8'hb8, 1'b1, 4'h1, 32'h81);
    run(1, 8'h01);
    bus(8'hb8, 1'b1, 4'h1, 32'hd0);
    run(8, 8'h80);
    bus(8'hb8, 1'b1, 4'h1, 32'hc1);
    run(8, 8'h08);
    bus(8'hc1, 1'b1, 4'hf, 32'h4000_0008);
    bus(8'hb8, 1'b1, 4'h1, 32'he0);
    run(16, 8'hf0);
    bus(8'hb8, 1'b0, 4'h1, 32'h0);
    chk("control readback", 32'he0, q);
    bus(8'hb7, 1'b0, 4'h1, 32'h0);
    chk("fifo port read", 32'h0, q);
    bus(8'h10, 1'b0, 4'h1, 32'h0);
    chk("unmapped err", 1, got_err);
    // Five writes into four places: the fifth must be dropped.
    for (int k = 1; k <= 5; k++) begin
      bus(8'hb7, 1'b1, 4'h1, 32'ha0 + k);
    end
    repeat (2) @(posedge clk_i);
    chk("tx not full", 0, nf);
    chk("head byte", 8'ha1, txd);
    // With the clock enable low a pop request must not move the FIFO.
    @(posedge clk_i);
    ce <= 1'b0;
    rd <= 1'b1;
    repeat (2) @(posedge clk_i);
    ce <= 1'b1;
    rd <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("frozen head", 8'ha1, txd);
    chk("frozen full", 0, nf);
    repeat (4) begin
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    chk("tx empty", 1, emp);
    chk("tx not full", 1, nf);
    end_sim();
  end
endmodule
